// ===== inc/isl_pkg.sv
`default_nettype none
package isl_pkg;
	// irq_control_main bit positions
	localparam int MAIN_PORT_CHANGE_FLAG   = 0;
	localparam int MAIN_PORT_CHANGE_ENABLE = 3;
	localparam int MAIN_TIMER_ENABLE       = 5;
	// irq_control_second bit positions
	localparam int SECOND_PORT_CHANGE_PRIO = 0;
	localparam int SECOND_TIMER_PRIO       = 2;
	// irq_control_third bit positions
	localparam int THIRD_EXT1_PRIO         = 6;
	localparam int THIRD_EXT2_PRIO         = 7;
	localparam logic [7:0]  TIMER8_TOP     = 8'hFF;
	localparam logic [15:0] TIMER16_TOP    = 16'hFFFF;
	localparam logic [2:0]  FLAGS_RESET    = 3'h0;
	localparam logic [7:0]  WORD_RESET     = 8'h00;
	localparam int PC_WIDTH                = 21;

	typedef struct packed {
		logic [7:0] working;
		logic [7:0] status;
		logic [7:0] bankSelect;
	} isl_context_t;

	typedef struct packed {
		logic [2:0] extEnable;
		logic [2:0] extPolarity;
		logic       extPrio1;
		logic       extPrio2;
		logic       timerEnable;
		logic       timerPrio;
		logic       portChangeEnable;
		logic       portChangePrio;
		logic       globalEnable;
		logic       priorityLevelsEnable;
		logic       timer16Mode;
	} isl_config_t;

	typedef enum logic [1:0] {
		ISL_RUN,
		ISL_ASLEEP,
		ISL_ENTRY
	} isl_state_t;
endpackage
`default_nettype wire

// ===== hdl/isl_interrupt_source_logic.sv
`default_nettype none
// How it works
// R01: external pin edge polarity: select 1 rising, 0 falling.
// R02: valid edge sets that pin's flag.
// R03: cleared pin enable blocks its interrupt request.
// R04: software clears pin flag before re-enabling; hardware never clears it.
// R05: enabled external pin interrupt wakes from idle or sleep; code wakes only on the pin enables latched at sleep entry.
// R06: after wake, vector only when global enable set.
// R07: pin one and two priority from third control bits 6 and 7.
// R08: pin zero has no priority bit, always high priority.
// R09: 8-bit mode: count FFh to 00h sets timer flag.
// R10: 16-bit mode: count FFFFh to 0000h sets timer flag.
// R11: timer enable at main control bit 5.
// R12: timer priority from second control bit 2.
// R13: change on port B bits 7..4 sets port-change flag, main bit 0.
// R14: port-change enable at main control bit 3.
// R15: port-change priority from second control bit 0.
// R16: interrupt entry pushes return address onto call stack.
// R17: interrupt entry copies working, status, bank select into shadow.
// R18: priority-levels enable: 1 two levels, 0 single legacy level.
// R19: without fast return, software saves context itself.
// R20: priority 1 routes to high vector, 0 to low vector.
module isl_interrupt_source_logic
	import isl_pkg::*;
#(
	parameter int PCW = PC_WIDTH
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [2:0]   extPinIn,
	input  wire logic [3:0]   portBPinsHigh,
	input  wire logic [7:0]   timerCountLow,
	input  wire logic [7:0]   timerCountHigh,
	input  wire isl_config_t  cfg,
	input  wire logic [2:0]   extFlagClear,
	input  wire logic         timerFlagClear,
	input  wire logic         portChangeFlagClear,
	input  wire logic         sleepRequest,
	input  wire logic         entryAck,
	input  wire logic         highServiceActive,
	input  wire logic         lowServiceActive,
	input  wire logic [PCW-1:0] returnPc,
	input  wire isl_context_t liveContext,
	output logic [2:0]        extPinFlag,
	output logic              timerFlag,
	output logic              portChangeFlag,
	output logic              asleep,
	output logic              wakeEvent,
	output logic              vectorHigh,
	output logic              vectorLow,
	output logic              stackPush,
	output logic [PCW-1:0]    stackPushData,
	output isl_context_t      shadowContext
);
	logic [2:0]  extSync1_r, extSync2_r, extPrev_r;
	logic [3:0]  portSync1_r, portSync2_r, portPrev_r;
	logic [15:0] timerPrev_r;
	logic        timer16Prev_r;
	logic [2:0]  asleepEnable_r;
	logic [1:0]  warm_r;
	isl_state_t  state_r;
	logic [2:0]  extEdge;
	logic        timerRoll;
	logic        portChange;
	logic [2:0]  extPrio;
	logic        reqHigh, reqLow, anyReq, wakeCause;

	function automatic logic prioOf(input logic bitValue, input logic levelsOn);
		return levelsOn ? bitValue : 1'b1;
	endfunction

	// input synchronisers
	always_ff @(posedge clk) begin
		if (!resetn) begin
			extSync1_r  <= FLAGS_RESET;
			extSync2_r  <= FLAGS_RESET;
			extPrev_r   <= FLAGS_RESET;
			portSync1_r <= 4'h0;
			portSync2_r <= 4'h0;
			portPrev_r  <= 4'h0;
		end else begin
			extSync1_r  <= extPinIn;
			extSync2_r  <= extSync1_r;
			extPrev_r   <= extSync2_r;
			portSync1_r <= portBPinsHigh;
			portSync2_r <= portSync1_r;
			portPrev_r  <= portSync2_r;
		end
	end

	// edge detect idles until the sync chain holds real pin levels
	always_ff @(posedge clk) begin
		if (!resetn)
			warm_r <= 2'h0;
		else if (warm_r != 2'h3)
			warm_r <= warm_r + 2'h1;
	end

	// R01: polarity edge select
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			extEdge[i] = (warm_r == 2'h3) && (cfg.extPolarity[i]
				? (extSync2_r[i] & ~extPrev_r[i]) : (~extSync2_r[i] & extPrev_r[i]));
		end
	end

	// R09: 8-bit rollover, R10: 16-bit rollover
	always_comb begin
		if (timer16Prev_r)
			timerRoll = (timerPrev_r == TIMER16_TOP) && ({timerCountHigh, timerCountLow} == 16'h0000);
		else
			timerRoll = (timerPrev_r[7:0] == TIMER8_TOP) && (timerCountLow == WORD_RESET);
	end

	// R13: change on port B upper nibble
	assign portChange = (warm_r == 2'h3) && (|(portSync2_r ^ portPrev_r));

	always_ff @(posedge clk) begin
		if (!resetn) begin
			timerPrev_r   <= 16'h0000;
			timer16Prev_r <= 1'b0;
		end else begin
			timerPrev_r   <= {timerCountHigh, timerCountLow};
			timer16Prev_r <= cfg.timer16Mode;
		end
	end

	// R02: edge sets flag, set wins over clear
	always_ff @(posedge clk) begin
		if (!resetn) begin
			extPinFlag <= FLAGS_RESET;
		end else begin
			extPinFlag <= (extPinFlag & ~extFlagClear) | extEdge;
		end
	end

	// R09: timer flag, set wins over clear
	always_ff @(posedge clk) begin
		if (!resetn) begin
			timerFlag <= 1'b0;
		end else begin
			timerFlag <= (timerFlag & ~timerFlagClear) | timerRoll;
		end
	end

	// R13: port-change flag
	always_ff @(posedge clk) begin
		if (!resetn) begin
			portChangeFlag <= 1'b0;
		end else begin
			portChangeFlag <= (portChangeFlag & ~portChangeFlagClear) | portChange;
		end
	end

	// R07: pin priorities, R08: pin zero fixed high
	assign extPrio = {cfg.extPrio2, cfg.extPrio1, 1'b1};

	// R03: enables gate requests, R20: route by priority, R18: levels
	always_comb begin
		reqHigh = 1'b0;
		reqLow  = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (extPinFlag[i] && cfg.extEnable[i]) begin
				if (prioOf(extPrio[i], cfg.priorityLevelsEnable))
					reqHigh = 1'b1;
				else
					reqLow = 1'b1;
			end
		end
		// R11: timer enable, R12: timer priority
		if (timerFlag && cfg.timerEnable) begin
			if (prioOf(cfg.timerPrio, cfg.priorityLevelsEnable))
				reqHigh = 1'b1;
			else
				reqLow = 1'b1;
		end
		// R14: port-change enable, R15: port-change priority
		if (portChangeFlag && cfg.portChangeEnable) begin
			if (prioOf(cfg.portChangePrio, cfg.priorityLevelsEnable))
				reqHigh = 1'b1;
			else
				reqLow = 1'b1;
		end
	end

	// R06: global enable gates entry, also after wake
	assign anyReq = cfg.globalEnable && !highServiceActive
		&& (reqHigh || (reqLow && !lowServiceActive));
	// R05: wake only by pins enabled before sleep
	assign wakeCause = |(extPinFlag & asleepEnable_r);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_r        <= ISL_RUN;
			asleep         <= 1'b0;
			asleepEnable_r <= FLAGS_RESET;
			wakeEvent      <= 1'b0;
			vectorHigh     <= 1'b0;
			vectorLow      <= 1'b0;
			stackPush      <= 1'b0;
			stackPushData  <= '0;
			shadowContext  <= '0;
		end else begin
			wakeEvent <= 1'b0;
			stackPush <= 1'b0;
			case (state_r)
				ISL_RUN: begin
					if (anyReq) begin
						state_r    <= ISL_ENTRY;
						vectorHigh <= reqHigh;
						vectorLow  <= !reqHigh;
						// R16: push return address
						stackPush     <= 1'b1;
						stackPushData <= returnPc;
						// R17: fast return shadow
						shadowContext <= liveContext;
					end else if (sleepRequest) begin
						state_r        <= ISL_ASLEEP;
						asleep         <= 1'b1;
						asleepEnable_r <= cfg.extEnable;
					end
				end
				ISL_ASLEEP: begin
					// R05: wake on latched enables
					if (wakeCause) begin
						asleep    <= 1'b0;
						wakeEvent <= 1'b1;
						state_r   <= ISL_RUN;
					end
				end
				ISL_ENTRY: begin
					if (entryAck) begin
						vectorHigh <= 1'b0;
						vectorLow  <= 1'b0;
						state_r    <= ISL_RUN;
					end
				end
				default: state_r <= ISL_RUN;
			endcase
		end
	end

	// R02: detected pin zero edge sets its flag next cycle
	ext_flag_set_a: assert property (@(posedge clk) disable iff (!resetn) // R02
		(extEdge[0]) |=> extPinFlag[0])
		else $error("pin zero edge did not set its flag");
	// R03: disabled sources never vector
	ext_enable_gate_a: assert property (@(posedge clk) disable iff (!resetn) // R03
		(state_r == ISL_RUN && (!cfg.globalEnable || !((|(extPinFlag & cfg.extEnable))
		|| (timerFlag && cfg.timerEnable) || (portChangeFlag && cfg.portChangeEnable))))
		|=> !stackPush)
		else $error("entry without an enabled source");
	// R07: pin one priority bit picks its level
	pin1_prio_a: assert property (@(posedge clk) disable iff (!resetn) // R07
		(state_r == ISL_RUN && anyReq && cfg.priorityLevelsEnable && extPinFlag == 3'h2
		&& !timerFlag && !portChangeFlag) |=> vectorHigh == $past(cfg.extPrio1))
		else $error("pin one priority ignored");
	// R06: wake without global enable gives no entry
	wake_novec_a: assert property (@(posedge clk) disable iff (!resetn) // R06
		(state_r == ISL_ASLEEP && wakeCause && !cfg.globalEnable) |=> ##1 !stackPush)
		else $error("entry after wake without global enable");
	// R08: pin zero always high vector
	pin0_high_a: assert property (@(posedge clk) disable iff (!resetn) // R08
		(state_r == ISL_RUN && anyReq && extPinFlag[0] && cfg.extEnable[0])
		|=> vectorHigh)
		else $error("pin zero not routed high");
	// R16: push carries return address
	push_data_a: assert property (@(posedge clk) disable iff (!resetn) // R16
		(state_r == ISL_RUN && anyReq) |=> stackPush && stackPushData == $past(returnPc))
		else $error("return address not pushed");
	// R17: shadow copy on entry
	shadow_copy_a: assert property (@(posedge clk) disable iff (!resetn) // R17
		stackPush |-> shadowContext == $past(liveContext))
		else $error("context shadow mismatch");
	// R18: single level routes everything high
	legacy_high_a: assert property (@(posedge clk) disable iff (!resetn) // R18
		(!cfg.priorityLevelsEnable && state_r == ISL_RUN && anyReq) |=> !vectorLow)
		else $error("low vector in legacy mode");
	// R09: timer rollover sets flag
	timer_flag_a: assert property (@(posedge clk) disable iff (!resetn) // R09
		timerRoll |=> timerFlag)
		else $error("timer rollover lost");
	// R13: port change sets flag
	port_flag_a: assert property (@(posedge clk) disable iff (!resetn) // R13
		portChange |=> portChangeFlag)
		else $error("port change lost");
	// R05: wake within one cycle of enabled pin flag
	sleep_wake_a: assert property (@(posedge clk) disable iff (!resetn) // R05
		(state_r == ISL_ASLEEP && wakeCause) |=> wakeEvent && !asleep)
		else $error("no wake on enabled pin");
	// R20: low-priority source alone goes low
	route_low_a: assert property (@(posedge clk) disable iff (!resetn) // R20
		(state_r == ISL_RUN && anyReq && !reqHigh) |=> vectorLow && !vectorHigh)
		else $error("low request misrouted");

	entry_high_c: cover property (@(posedge clk) disable iff (!resetn)
		stackPush && vectorHigh);
	entry_low_c: cover property (@(posedge clk) disable iff (!resetn)
		stackPush && vectorLow);
	wake_c: cover property (@(posedge clk) disable iff (!resetn) wakeEvent);
	timer16_c: cover property (@(posedge clk) disable iff (!resetn)
		timerRoll && timer16Prev_r);
endmodule
`default_nettype wire

// ===== dv/isl_core_model.sv
`default_nettype none
module isl_core_model
	import isl_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       vectorHigh,
	input  wire logic       vectorLow,
	input  wire logic [2:0] ackDelay,
	output logic            entryAck,
	output logic            highServiceActive,
	output logic            lowServiceActive
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] waitCnt_r;
	logic [1:0] svcCnt_r;
	logic       svcHigh_r;
	// slow or prompt acknowledge, never in the vector's first cycle
	always_ff @(posedge clk) begin
		if (!resetn || !(vectorHigh || vectorLow) || entryAck)
			waitCnt_r <= 3'h0;
		else
			waitCnt_r <= waitCnt_r + 3'h1;
	end
	always_ff @(posedge clk) begin
		entryAck <= resetn && (vectorHigh || vectorLow) && !entryAck && waitCnt_r >= ackDelay;
	end
	// short handler of the level taken
	always_ff @(posedge clk) begin
		if (!resetn)
			svcCnt_r <= 2'h0;
		else if (entryAck)
			svcCnt_r <= 2'h3;
		else if (svcCnt_r != 2'h0)
			svcCnt_r <= svcCnt_r - 2'h1;
		if (entryAck)
			svcHigh_r <= vectorHigh;
	end
	assign highServiceActive = svcCnt_r != 2'h0 && svcHigh_r;
	assign lowServiceActive  = svcCnt_r != 2'h0 && !svcHigh_r;
endmodule
`default_nettype wire

// ===== dv/isl_interrupt_source_logic_tb_top.sv
`default_nettype none
module isl_interrupt_source_logic_tb_top
	import isl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic h; logic l; logic [PC_WIDTH-1:0] pc; isl_context_t ctx;
	} isl_entry_t;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [2:0] extPinIn = 3'h7;
	logic [3:0] portBPinsHigh = 4'h0;
	logic [7:0] timerCountLow = 8'h10;
	logic [7:0] timerCountHigh = 8'h00;
	isl_config_t cfg = '0;
	logic [2:0] extFlagClear = 3'h0;
	logic timerFlagClear = 1'b0;
	logic portChangeFlagClear = 1'b0;
	logic sleepRequest = 1'b0;
	logic [PC_WIDTH-1:0] returnPc = '0;
	isl_context_t liveContext = '0;
	logic [2:0] ackDelay = 3'h1;
	logic entryAck, highServiceActive, lowServiceActive, timerFlag, portChangeFlag;
	logic asleep, wakeEvent, vectorHigh, vectorLow, stackPush;
	logic [2:0] extPinFlag;
	logic [PC_WIDTH-1:0] stackPushData;
	isl_context_t shadowContext;
	logic [6:0] obs;
	int nFail = 0;
	int checked = 0;
	integer seed = 32'h8947B14A;
	isl_entry_t expQ[$];
	assign obs = {asleep, wakeEvent, portChangeFlag, timerFlag, extPinFlag};
	always #10 clk = ~clk;
	isl_interrupt_source_logic dut (.clk(clk), .resetn(resetn), .extPinIn(extPinIn),
		.portBPinsHigh(portBPinsHigh), .timerCountLow(timerCountLow),
		.timerCountHigh(timerCountHigh), .cfg(cfg), .extFlagClear(extFlagClear),
		.timerFlagClear(timerFlagClear), .portChangeFlagClear(portChangeFlagClear),
		.sleepRequest(sleepRequest), .entryAck(entryAck), .highServiceActive(highServiceActive),
		.lowServiceActive(lowServiceActive), .returnPc(returnPc), .liveContext(liveContext),
		.extPinFlag(extPinFlag), .timerFlag(timerFlag), .portChangeFlag(portChangeFlag),
		.asleep(asleep), .wakeEvent(wakeEvent), .vectorHigh(vectorHigh), .vectorLow(vectorLow),
		.stackPush(stackPush), .stackPushData(stackPushData), .shadowContext(shadowContext));
	isl_core_model core (.clk(clk), .resetn(resetn), .vectorHigh(vectorHigh),
		.vectorLow(vectorLow), .ackDelay(ackDelay), .entryAck(entryAck),
		.highServiceActive(highServiceActive), .lowServiceActive(lowServiceActive));
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic cmpBit(string what, logic exp, logic got);
		checked++;
		if (got !== exp) begin
			nFail++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic cmpEntry(isl_entry_t exp, isl_entry_t got);
		checked++;
		if (got !== exp) begin
			nFail++;
			$display("BAD entry expected %h seen %h", exp, got);
		end
	endtask
	task automatic test_done();
		$display("checked %0d mismatches %0d", checked, nFail);
		if (nFail == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// index 7 waits for every noted entry to be seen
	task automatic waitFor(string what, int idx);
		int k;
		k = 0;
		while (idx > 6 ? expQ.size() != 0 : obs[idx] !== 1'b1) begin
			step(1);
			k++;
			if (k > 20) begin
				nFail++;
				$display("BAD %s expected 1 seen timeout", what);
				test_done();
			end
		end
		cmpBit(what, 1'b1, idx > 6 ? expQ.size() == 0 : obs[idx]);
	endtask
	task automatic clearAll();
		extFlagClear = 3'h7;
		timerFlagClear = 1'b1;
		portChangeFlagClear = 1'b1;
		step(1);
		extFlagClear = 3'h0;
		timerFlagClear = 1'b0;
		portChangeFlagClear = 1'b0;
		step(1);
	endtask
	task automatic expectEntry(logic hi);
		returnPc = PC_WIDTH'($random(seed));
		liveContext = isl_context_t'(24'($random(seed)));
		ackDelay = 3'h1 + 3'($random(seed) & 3);
		expQ.push_back({hi, !hi, returnPc, liveContext});
	endtask
	always @(posedge clk) begin
		if (stackPush === 1'b1) begin
			if (expQ.size() == 0) begin
				nFail++;
				$display("BAD entry expected none seen %b", stackPush);
			end else begin
				cmpEntry(expQ.pop_front(), {vectorHigh, vectorLow, stackPushData, shadowContext});
			end
		end
	end
	initial begin
		step(4);
		resetn = 1'b1;
		cfg.globalEnable = 1'b1;
		cfg.extPrio2 = 1'b1;
		step(1);
		for (int i = 0; i < 3; i++) begin
			for (int p = 0; p < 2; p++) begin
				cfg.extPolarity[i] = p[0];
				extPinIn[i] = !p[0];
				step(4);
				clearAll();
				extPinIn[i] = p[0];
				waitFor("extPinFlag", i);
				clearAll();
			end
		end
		$display("test edges done");
		for (int lv = 0; lv < 2; lv++) begin
			cfg.priorityLevelsEnable = lv[0];
			for (int i = 0; i < 3; i++) begin
				cfg.extPolarity[i] = !extPinIn[i];
				cfg.extEnable = 3'h1 << i;
				clearAll();
				expectEntry(!(lv == 1 && i == 1));
				extPinIn[i] = !extPinIn[i];
				waitFor("entry", 7);
				clearAll();
				step(6);
			end
		end
		$display("test pin entries done");
		cfg.extEnable = 3'h0;
		cfg.timerEnable = 1'b1;
		for (int m = 0; m < 2; m++) begin
			cfg.timer16Mode = m[0];
			step(2);
			for (int k = 0; k < 2; k++) begin
				{timerCountHigh, timerCountLow} = k ? 16'hFFFF : 16'h00FF;
				step(1);
				if (k == 1 || m == 0)
					expectEntry(1'b0);
				{timerCountHigh, timerCountLow} = 16'h0000;
				step(4);
				cmpBit("timerFlag", k == 1 || m == 0, timerFlag);
				waitFor("entry", 7);
				clearAll();
				step(6);
			end
		end
		$display("test timer done");
		cfg.timerEnable = 1'b0;
		cfg.portChangeEnable = 1'b1;
		cfg.portChangePrio = 1'b1;
		for (int k = 0; k < 4; k++) begin
			expectEntry(1'b1);
			portBPinsHigh = portBPinsHigh ^ (4'h1 << k);
			waitFor("portChangeFlag", 4);
			waitFor("entry", 7);
			clearAll();
			step(6);
		end
		$display("test port change done");
		cfg.portChangeEnable = 1'b0;
		cfg.extEnable = 3'h1;
		for (int g = 0; g < 2; g++) begin
			cfg.globalEnable = g[0];
			cfg.extPolarity[0] = !extPinIn[0];
			clearAll();
			sleepRequest = 1'b1;
			waitFor("asleep", 6);
			sleepRequest = 1'b0;
			if (g == 1)
				expectEntry(1'b1);
			extPinIn[0] = !extPinIn[0];
			waitFor("wakeEvent", 5);
			clearAll();
			step(6);
			cmpBit("asleep", 1'b0, asleep);
			cmpBit("wake entries", 1'b1, expQ.size() == 0);
		end
		$display("test wake done");
		test_done();
	end
endmodule
`default_nettype wire
